// *** task_sync_consts.svh ***
/*
 * Constants for the task period scheduler with shared sync trigger:
 * register offsets, field positions, reset values, codes and times.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef TASK_SYNC_CONSTS_SVH
`define TASK_SYNC_CONSTS_SVH

// Register byte offsets
`define OFF_CTRL            8'h00
`define OFF_STATUS          8'h04
`define OFF_INTERVAL        8'h08

// Control register fields
`define CTRL_PERIOD_LSB     0
`define CTRL_PERIOD_MSB     2
`define CTRL_ROLE_LSB       4
`define CTRL_ROLE_MSB       5
`define CTRL_SERIAL_LSB     8
`define CTRL_SERIAL_MSB     15

// Reset values
`define RST_PERIOD_SEL      3'h1
`define RST_ROLE            2'h0
`define RST_SERIAL_MODE     8'h01

// Period selector codes
`define PERIOD_SEL_MIN      3'h1
`define PERIOD_SEL_MAX      3'h6

// Role codes
`define ROLE_PRODUCER       2'h1
`define ROLE_CONSUMER       2'h2

// Serial sync mode meaning slave of the inter-drive scheme
`define SERIAL_MODE_SLAVE   8'h1A

// Status codes
`define STAT_NONE           8'h00
`define STAT_TOO_SLOW       8'h02
`define STAT_PRODUCER       8'h05
`define STAT_CONSUMER       8'h06
`define STAT_PRODUCER_EXT   8'h0D

// Timing: clock period and shortest task period, in ns
`define CLK_PERIOD_NS       5
`define BASE_PERIOD_NS      250000

// Allowed jitter of a measured trigger interval, in cycles
`define MEAS_TOL            24'h000004

`endif

// *** task_sync_pkg.sv ***
/*
 * Types shared by the task period scheduler.
 * Assumes task_sync_consts.svh is on the include path.
 */
package task_sync_pkg;
    // Sequencing of the three position tasks inside one period
    typedef enum logic [1:0] {
        TASK_IDLE,
        TASK_FIRST,
        TASK_ADVANCED,
        TASK_SECOND
    } task_state_t;
endpackage

// *** task_period_sync_trigger.sv ***
/*
 * Task period scheduler with shared synchronisation trigger, APB slave.
 * Assumes: pclk 200 MHz, presetn async active low, trigger and
 * inter-drive sync pins asynchronous, task done strobes on pclk.
 */
//
// Behaviour
// - Role 1 produces trigger, 2 consumes
// - Producer pulses trigger every period start
// - Selector 1..6 gives 250us..8ms periods
// - Trigger re-phases consumer period timer
// - Consumer syncs if own period not longer
// - Longer-period consumer ignores trigger, runs free
// - Status 5 producer, 6 consumer achieved
// - Status 13 producing under inter-drive sync
// - Status 2 when consumer period too long
// - Status is read-only, reflects achieved role
// - Serial sync slave forces role to producer
// - Tasks start first, advanced, then second
// - Only the task group start is aligned
`include "task_sync_consts.svh"

module task_period_sync_trigger #(
    parameter int BASE_PERIOD_CYCLES = `BASE_PERIOD_NS / `CLK_PERIOD_NS,
    parameter int CNT_W              = 24
) (
    input  wire logic        pclk,                         // APB clock
    input  wire logic        presetn,                      // Async reset, active low
    input  wire logic        psel,                         // APB select
    input  wire logic        penable,                      // APB enable
    input  wire logic        pwrite,                       // APB direction
    input  wire logic [7:0]  paddr,                        // APB byte address
    input  wire logic [31:0] pwdata,                       // APB write data
    output logic      [31:0] prdata,                       // APB read data
    output logic             pready,                       // APB ready
    output logic             pslverr,                      // APB error
    input  wire logic        sync_trigger_in,              // Trigger from other modules
    output logic             sync_trigger_out,             // Trigger pulse to others
    input  wire logic        inter_drive_sync_signal,      // Serial scheme sync pin
    output logic             first_position_task,          // First task start pulse
    output logic             advanced_position_task,       // Advanced task start pulse
    output logic             second_position_task,         // Second task start pulse
    input  wire logic        first_task_done,              // First task finished
    input  wire logic        advanced_task_done,           // Advanced task finished
    input  wire logic        second_task_done              // Second task finished
);

    generate
        if (BASE_PERIOD_CYCLES < 4 || CNT_W > 31 || (64'(BASE_PERIOD_CYCLES) * 64'd32) >= (64'd1 << CNT_W))
        begin : g_bad_params
            $error("task_period_sync_trigger: period does not fit counter");
        end
    endgenerate

    // Period decode: base period doubled per selector step
    function automatic logic [CNT_W-1:0] period_cycles(input logic [2:0] sel);
        logic [CNT_W-1:0] base;
        base = CNT_W'(BASE_PERIOD_CYCLES);
        if (sel >= `PERIOD_SEL_MIN && sel <= `PERIOD_SEL_MAX)
            period_cycles = base << (sel - `PERIOD_SEL_MIN);
        else
            period_cycles = '0;
    endfunction

    logic [2:0]             task_period_select;
    logic [1:0]             sync_role_select;
    logic [7:0]             serial_sync_mode_select;
    logic [7:0]             sync_status_value;
    logic [2:0]             trig_sync;
    logic [2:0]             idrv_sync;
    logic [CNT_W-1:0]       period_cnt;
    logic [CNT_W-1:0]       meas_cnt;
    logic [CNT_W-1:0]       producer_period;
    logic                   have_period;
    logic                   rephased;
    logic                   idrv_seen;
    task_sync_pkg::task_state_t state;
    task_sync_pkg::task_state_t next_state;
    logic [7:0]             next_status;

    // Decode and selection
    wire              serial_slave = (serial_sync_mode_select == `SERIAL_MODE_SLAVE);
    wire              is_producer  = (sync_role_select == `ROLE_PRODUCER);
    wire              is_consumer  = (sync_role_select == `ROLE_CONSUMER);
    wire [CNT_W-1:0]  own_period   = period_cycles(task_period_select);
    wire              period_ok    = (own_period != '0);
    wire              trig_edge    = trig_sync[1] & ~trig_sync[2];
    wire              idrv_edge    = idrv_sync[1] & ~idrv_sync[2];
    wire              sync_ok      = have_period && (own_period <= producer_period + CNT_W'(`MEAS_TOL));
    wire              wrap         = period_ok && (period_cnt >= own_period - CNT_W'(1));
    wire              consumer_rephase = is_consumer && period_ok && trig_edge && sync_ok;
    wire              producer_rephase = is_producer && period_ok && serial_slave && idrv_edge;
    wire              resync       = consumer_rephase | producer_rephase;
    wire              period_start = wrap | resync;
    wire              apb_access   = psel & penable;
    wire              wr_ctrl      = apb_access & pwrite & (paddr == `OFF_CTRL);
    wire              addr_known   = (paddr == `OFF_CTRL) || (paddr == `OFF_STATUS) || (paddr == `OFF_INTERVAL);

    // Two flip-flops on each pin before use, third for the edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            trig_sync <= 3'h0;
            idrv_sync <= 3'h0;
        end
        else
        begin
            trig_sync <= {trig_sync[1:0], sync_trigger_in};
            idrv_sync <= {idrv_sync[1:0], inter_drive_sync_signal};
        end
    end

    // Control register; the serial slave force beats a software write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            task_period_select      <= `RST_PERIOD_SEL;
            sync_role_select        <= `RST_ROLE;
            serial_sync_mode_select <= `RST_SERIAL_MODE;
        end
        else
        begin
            if (wr_ctrl)
            begin
                task_period_select      <= pwdata[`CTRL_PERIOD_MSB:`CTRL_PERIOD_LSB];
                sync_role_select        <= pwdata[`CTRL_ROLE_MSB:`CTRL_ROLE_LSB];
                serial_sync_mode_select <= pwdata[`CTRL_SERIAL_MSB:`CTRL_SERIAL_LSB];
            end
            if (serial_slave)
                sync_role_select <= `ROLE_PRODUCER;
        end
    end

    // Period timer: wraps free, restarted by an accepted trigger
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            period_cnt <= '0;
        else if (!period_ok || period_start)
            period_cnt <= '0;
        else
            period_cnt <= period_cnt + CNT_W'(1);
    end

    // Trigger out only from the producer, one cycle per period
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sync_trigger_out <= 1'b0;
        else
            sync_trigger_out <= is_producer & period_start;
    end

    // Measure producer period between trigger edges; saturates when none come
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meas_cnt        <= '1; // Saturated: first edge only starts a measurement
            producer_period <= '0;
            have_period     <= 1'b0;
        end
        else if (trig_edge)
        begin
            meas_cnt        <= CNT_W'(1);
            producer_period <= meas_cnt;
            have_period     <= (meas_cnt != '0) && (meas_cnt != '1);
        end
        else if (meas_cnt != '1)
            meas_cnt <= meas_cnt + CNT_W'(1);
        else
            have_period <= 1'b0; // Trigger stopped: producer period unknown
    end

    // Achievement flags, dropped when the role changes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rephased  <= 1'b0;
            idrv_seen <= 1'b0;
        end
        else
        begin
            // Set beats clear: a re-phase in the write cycle still counts
            if (consumer_rephase)
                rephased <= 1'b1;
            else if (wr_ctrl || !is_consumer || !have_period || !sync_ok)
                rephased <= 1'b0;
            if (producer_rephase)
                idrv_seen <= 1'b1;
            else if (wr_ctrl || !serial_slave || !is_producer)
                idrv_seen <= 1'b0;
        end
    end

    // Status value is computed from hardware state only; writes ignored
    always_comb
    begin
        next_status = `STAT_NONE;
        if (is_producer && period_ok)
            next_status = (serial_slave && idrv_seen) ? `STAT_PRODUCER_EXT : `STAT_PRODUCER;
        else if (is_consumer && period_ok && have_period && !sync_ok)
            next_status = `STAT_TOO_SLOW;
        else if (is_consumer && rephased)
            next_status = `STAT_CONSUMER;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sync_status_value <= `STAT_NONE;
        else
            sync_status_value <= next_status;
    end

    // Task sequencing; a new period restarts the group even if late
    always_comb
    begin
        next_state = state;
        unique case (state)
            task_sync_pkg::TASK_IDLE:     next_state = state;
            task_sync_pkg::TASK_FIRST:    if (first_task_done) next_state = task_sync_pkg::TASK_ADVANCED;
            task_sync_pkg::TASK_ADVANCED: if (advanced_task_done) next_state = task_sync_pkg::TASK_SECOND;
            task_sync_pkg::TASK_SECOND:   if (second_task_done) next_state = task_sync_pkg::TASK_IDLE;
        endcase
        if (period_start)
            next_state = task_sync_pkg::TASK_FIRST;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state                  <= task_sync_pkg::TASK_IDLE;
            first_position_task    <= 1'b0;
            advanced_position_task <= 1'b0;
            second_position_task   <= 1'b0;
        end
        else
        begin
            state                  <= next_state;
            first_position_task    <= period_start;
            advanced_position_task <= !period_start && state == task_sync_pkg::TASK_FIRST && first_task_done;
            second_position_task   <= !period_start && state == task_sync_pkg::TASK_ADVANCED && advanced_task_done;
        end
    end

    // APB answers in the access cycle; unmapped addresses flag an error
    assign pready  = 1'b1;
    assign pslverr = apb_access & ~addr_known;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (psel && !penable && !pwrite)
        begin
            unique case (paddr)
                `OFF_CTRL:     prdata <= {16'h0000, serial_sync_mode_select, 2'h0, sync_role_select,
                                          1'b0, task_period_select};
                `OFF_STATUS:   prdata <= {24'h000000, next_status};
                `OFF_INTERVAL: prdata <= 32'(producer_period);
                default:       prdata <= 32'h00000000;
            endcase
        end
    end

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic [CNT_W-1:0] since_start;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            since_start <= '0;
        else if (period_start || !period_ok)
            since_start <= '0;
        else
            since_start <= since_start + CNT_W'(1);
    end

    sequence s_first_run;
        state == task_sync_pkg::TASK_FIRST && first_task_done && !period_start;
    endsequence

    sequence s_adv_run;
        state == task_sync_pkg::TASK_ADVANCED && advanced_task_done && !period_start;
    endsequence

    chk_trigger_producer_only: assert property (
        sync_trigger_out |-> $past(is_producer) && $past(period_start))
        else $error("trigger out without producer period start");

    chk_free_period_length: assert property (
        (wrap && !resync && $stable(task_period_select)) |-> since_start == own_period - CNT_W'(1))
        else $error("period start not one period after the last");

    chk_period_decode: assert property (
        task_period_select == 3'h4 |-> own_period == CNT_W'(BASE_PERIOD_CYCLES) * CNT_W'(8))
        else $error("selector 4 not eight base periods");

    chk_consumer_rephase: assert property (
        consumer_rephase |=> period_cnt == '0 ##0 first_position_task)
        else $error("accepted trigger did not restart period");

    chk_slow_no_rephase: assert property (
        (is_consumer && trig_edge && !sync_ok && !wrap) |=> period_cnt != '0 || !period_ok)
        else $error("slow consumer re-phased to trigger");

    chk_status_roles: assert property (
        sync_status_value == `STAT_CONSUMER |-> $past(is_consumer) && $past(rephased))
        else $error("consumer status without consumer sync");

    chk_rephase_flag: assert property (
        consumer_rephase |=> rephased)
        else $error("accepted trigger not recorded for status");

    chk_status_ext: assert property (
        (is_producer && serial_slave && idrv_seen && period_ok && !wr_ctrl) |=> sync_status_value == `STAT_PRODUCER_EXT)
        else $error("status not 13 under inter-drive sync");

    chk_status_slow: assert property (
        (is_consumer && period_ok && have_period && !sync_ok) |=> sync_status_value == `STAT_TOO_SLOW)
        else $error("status not 2 for slow consumer");

    chk_role_forced: assert property (
        serial_slave |=> sync_role_select == `ROLE_PRODUCER)
        else $error("serial slave did not force producer role");

    chk_task_order: assert property (
        s_first_run |=> advanced_position_task ##0 state == task_sync_pkg::TASK_ADVANCED)
        else $error("advanced task did not follow first task");

    chk_second_after_adv: assert property (
        s_adv_run |=> second_position_task && !first_position_task && !advanced_position_task)
        else $error("second task did not follow advanced task");

endmodule // task_period_sync_trigger

// *** peer_option_module.sv ***
/*
 * Model of the other option modules on the drive: a trigger producer
 * and the task software that answers each unaborted task start with a done strobe.
 * Assumes the shared pclk domain and the block's async presetn.
 */
module peer_option_module (
    input  wire logic       pclk,         // Shared clock
    input  wire logic       presetn,      // Async reset, active low
    input  wire logic       trig_en,      // Act as producer
    input  wire logic [7:0] trig_period,  // Trigger period in cycles
    input  wire logic [3:0] done_delay,   // Task run time in cycles
    input  wire logic       first_start,  // First task start pulse
    input  wire logic       adv_start,    // Advanced task start pulse
    input  wire logic       second_start, // Second task start pulse
    output logic            trig,         // Trigger toward the block
    output logic            first_done,   // First task finished
    output logic            adv_done,     // Advanced task finished
    output logic            second_done   // Second task finished
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] tcnt;
    logic [3:0] run;
    logic [1:0] stage;

    // Trigger held high four cycles so the block's synchroniser cannot miss it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tcnt <= 8'h00;
            trig <= 1'b0;
        end
        else
        begin
            tcnt <= (tcnt >= trig_period - 8'h01) ? 8'h00 : tcnt + 8'h01;
            trig <= trig_en && (tcnt < 8'h04);
        end
    end

    // Tasks run one at a time; a new start aborts the one in progress
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run   <= 4'h0;
            stage <= 2'h0;
        end
        else if (first_start || adv_start || second_start)
        begin
            run   <= {1'b0, done_delay[2:0]} + 4'h1;
            stage <= first_start ? 2'h1 : (adv_start ? 2'h2 : 2'h3);
        end
        else if (run != 4'h0)
            run <= run - 4'h1;
    end

    // Done strobes last one cycle, in the state of the task that ran
    assign first_done  = (run == 4'h1) && (stage == 2'h1);
    assign adv_done    = (run == 4'h1) && (stage == 2'h2);
    assign second_done = (run == 4'h1) && (stage == 2'h3);
endmodule // peer_option_module

// *** task_period_sync_trigger_bench.sv ***
/*
 * Self-checking bench for the task period scheduler: APB register
 * access, producer periods, consumer re-phasing and status codes.
 * Assumes BASE_PERIOD_CYCLES shortened to 16 and a peer model on the pins.
 */
module task_period_sync_trigger_bench;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int BASE = 16;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, trig_period;
    logic [31:0] pwdata, prdata, seed;
    logic        trig, trig_out, idsync, t_first, t_adv, t_second;
    logic        d_first, d_adv, d_second, trig_en, trig_d, armed;
    logic [3:0]  done_delay;
    logic [1:0]  order;
    logic [32:0] exp_q[$];
    int          n_fail, n_tests, since_first, gap_first, since_tout, gap_tout;
    int          since_trig, lat;

    task_period_sync_trigger #(.BASE_PERIOD_CYCLES(BASE)) i_task_period_sync_trigger (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sync_trigger_in(trig),
        .sync_trigger_out(trig_out), .inter_drive_sync_signal(idsync),
        .first_position_task(t_first), .advanced_position_task(t_adv),
        .second_position_task(t_second), .first_task_done(d_first),
        .advanced_task_done(d_adv), .second_task_done(d_second));

    peer_option_module i_peer_option_module (
        .pclk(pclk), .presetn(presetn), .trig_en(trig_en), .trig_period(trig_period),
        .done_delay(done_delay), .first_start(t_first), .adv_start(t_adv),
        .second_start(t_second), .trig(trig), .first_done(d_first),
        .adv_done(d_adv), .second_done(d_second));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic check(input string what, input logic [32:0] exp, input logic [32:0] got);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic close_out;
        if (n_fail == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // One APB transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No wait-state count assumed; only the watchdog ends a hang
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Expected {pslverr, prdata} noted before the read goes out
    task automatic rd(input logic [7:0] a, input logic [32:0] exp);
        exp_q.push_back(exp);
        apb(1'b0, a, 32'h00000000);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // Output watcher: read data, pulse spacing, trigger latency, task order
    always @(posedge pclk)
    begin
        if (psel && penable && pready && !pwrite && exp_q.size() > 0)
            check("apb read", exp_q.pop_front(), {pslverr, prdata});
        if (trig && !trig_d)
        begin
            since_trig = 0;
            armed = 1'b1;
        end
        if (t_first && armed)
        begin
            lat = since_trig;
            armed = 1'b0;
        end
        if (t_first)
        begin
            gap_first = since_first;
            since_first = 0;
            order = 2'h1;
            seed = lfsr(seed);
            done_delay <= seed[3:0] & 4'h7;
        end
        if (t_adv)
        begin
            check("advanced after first", 2'h1, order);
            order = 2'h2;
        end
        if (t_second)
        begin
            check("second after advanced", 2'h2, order);
            order = 2'h3;
        end
        if (trig_out)
        begin
            gap_tout = since_tout;
            since_tout = 0;
        end
        since_first++;
        since_tout++;
        since_trig++;
        trig_d = trig;
    end

    initial
    begin
        #150000;
        n_fail++;
        close_out();
    end

    initial
    begin
        {presetn, psel, penable, pwrite, idsync, trig_en, trig_d, armed} = 8'h00;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        done_delay = 4'h2;
        trig_period = 8'h20;
        order = 2'h0;
        seed = 32'hE5317F5D;
        {n_fail, n_tests, since_first, since_tout, since_trig} = '0;
        {gap_first, gap_tout, lat} = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h00, {1'b0, 32'h00000101});
        rd(8'h04, {1'b0, 32'h00000000});
        rd(8'h0C, {1'b1, 32'h00000000});
        // Producer at selectors 1 to 4, peer silent
        for (int s = 1; s <= 4; s++)
        begin
            apb(1'b1, 8'h00, 32'h00000010 | s);
            wait_cyc(3 * (BASE << (s - 1)) + 10);
            check("trigger spacing", BASE << (s - 1), gap_tout);
            check("task group spacing", BASE << (s - 1), gap_first);
            rd(8'h04, {1'b0, 32'h00000005});
        end
        apb(1'b1, 8'h04, 32'h000000FF);
        rd(8'h04, {1'b0, 32'h00000005});
        // Consumer faster than the peer producer, random phase
        apb(1'b1, 8'h00, 32'h00000021);
        seed = lfsr(seed);
        wait_cyc(seed[4:0]);
        trig_en <= 1'b1;
        wait_cyc(200);
        check("consumer spacing", BASE, gap_first);
        check("trigger to task start", 1'b1, lat >= 2 && lat <= 5);
        rd(8'h04, {1'b0, 32'h00000006});
        rd(8'h08, {1'b0, 24'h000000, trig_period});
        // Consumer slower than the peer producer
        apb(1'b1, 8'h00, 32'h00000023);
        wait_cyc(300);
        rd(8'h04, {1'b0, 32'h00000002});
        check("slow consumer spacing", BASE * 4, gap_first);
        // Trigger stops: consumer keeps its own period
        apb(1'b1, 8'h00, 32'h00000021);
        trig_en <= 1'b0;
        wait_cyc(100);
        check("free running spacing", BASE, gap_first);
        // Serial scheme slave forces producer role
        apb(1'b1, 8'h00, 32'h00001A23);
        rd(8'h00, {1'b0, 32'h00001A13});
        idsync <= 1'b1;
        wait_cyc(4);
        idsync <= 1'b0;
        wait_cyc(300);
        rd(8'h04, {1'b0, 32'h0000000D});
        check("group spacing under slave", BASE * 4, gap_first);
        close_out();
    end
endmodule // task_period_sync_trigger_bench
